// ==== hw/bts_addr_resolve.sv ====
`timescale 1ns/1ps
module bts_addr_resolve (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic                          load,
   input  wire bts_pkg::bts_fields_t          fields,
   input  wire logic                          ext_set_en,
   input  wire logic [bts_pkg::BANK_W-1:0]    bank_select_register,
   input  wire logic [bts_pkg::ADDR_W-1:0]    index_base,
   output logic      [bts_pkg::ADDR_W-1:0]    addr_r,
   output logic                               indexed_r
);

   logic [bts_pkg::ADDR_W-1:0] addr_nxt;
   logic                       indexed_nxt;

   // ***********************************
   // Operand address selection
   // ***********************************
   // Bank choice is frozen at decode so a later bank change cannot tear the access
   always_comb begin
      addr_nxt    = addr_r;
      indexed_nxt = indexed_r;
      if (load) begin
         if (!fields.acc_flag && ext_set_en && fields.file_addr <= bts_pkg::INDEX_LIMIT) begin
            addr_nxt    = bts_pkg::ADDR_W'(index_base + {4'h0, fields.file_addr}); // [RULE_08]
            indexed_nxt = 1'b1;
         end else if (!fields.acc_flag) begin
            indexed_nxt = 1'b0;
            if (fields.file_addr >= bts_pkg::ACCESS_SPLIT)                          // [RULE_07]
               addr_nxt = {bts_pkg::ACCESS_HIGH, fields.file_addr};
            else
               addr_nxt = {bts_pkg::ACCESS_LOW, fields.file_addr};
         end else begin
            indexed_nxt = 1'b0;
            addr_nxt    = {bank_select_register, fields.file_addr};                 // [RULE_07]
         end
      end
   end

   // Register only
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         addr_r    <= '0;
         indexed_r <= 1'b0;
      end else begin
         addr_r    <= addr_nxt;
         indexed_r <= indexed_nxt;
      end
   end

endmodule : bts_addr_resolve

// ==== hw/bts_decode.sv ====
// Summary of operation
// RULE_01 - Nibble 1011 decodes as skip-if-bit-clear
// RULE_02 - Nibble 1010 decodes as skip-if-bit-set
// RULE_03 - Clear bit skips next; no flags touched
// RULE_04 - Taken skip discards prefetch, runs no-operation
// RULE_05 - One cycle, two if skip, three two-word
// RULE_06 - Extra cycles idle in all four quarters
// RULE_07 - Flag zero access bank, one uses bank
// RULE_08 - Extended set, flag zero, f<=95: indexed
// RULE_09 - Q1 decode, Q2 read, Q3 test, Q4 none
`timescale 1ns/1ps
module bts_decode (
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   input  wire logic [bts_pkg::WORD_W-1:0]    instr_word,
   input  wire logic                          next_two_word,
   input  wire logic                          ext_set_en,
   input  wire logic [bts_pkg::BANK_W-1:0]    bank_select_register,
   input  wire logic [bts_pkg::ADDR_W-1:0]    index_base,
   input  wire logic [7:0]                    file_rd_data,
   output logic      [1:0]                    q_phase_r,
   output logic                               bit_op_r,
   output logic                               file_rd_en_r,
   output logic      [bts_pkg::ADDR_W-1:0]    file_addr_r,
   output logic                               indexed_r,
   output logic                               skip_r,
   output logic                               discard_r,
   output logic                               no_operation_r,
   output logic                               instr_done_r
);

   // ***********************************
   // Declarations
   // ***********************************
   // Phase and sequencer state
   bts_pkg::bts_quarter_t q_r;
   bts_pkg::bts_quarter_t q_nxt;
   bts_pkg::bts_state_t   st_r;
   bts_pkg::bts_state_t   st_nxt;

   // Operands of the instruction in the execute slot
   bts_pkg::bts_fields_t  fields;
   bts_pkg::bts_fields_t  fld_r;
   bts_pkg::bts_fields_t  fld_nxt;
   logic                  set_pol_r;
   logic                  set_pol_nxt;
   logic                  load;
   logic [3:0]            opc;

   // Test outcome and pacing of the idle cycles
   logic                  tested_r;
   logic                  tested_nxt;
   logic                  skip_nxt;
   logic                  two_r;
   logic                  two_nxt;

   // Next values of the registered strobes
   logic                  bit_op_nxt;
   logic                  rd_en_nxt;
   logic                  discard_nxt;
   logic                  nop_nxt;
   logic                  done_nxt;

   // ***********************************
   // Instruction word split
   // ***********************************
   // Opcode match for both skip-test opcodes
   function automatic logic is_bit_test(input logic [3:0] op);
      is_bit_test = (op == bts_pkg::OPC_SKIP_CLR) || (op == bts_pkg::OPC_SKIP_SET);
   endfunction : is_bit_test

   // Operand fields below the opcode nibble; one driver for the whole struct
   function automatic bts_pkg::bts_fields_t split_fields(input logic [bts_pkg::WORD_W-1:0] w);
      split_fields.bit_idx   = w[bts_pkg::BIT_LSB +: 3];
      split_fields.acc_flag  = w[bts_pkg::ACC_POS];
      split_fields.file_addr = w[bts_pkg::FILE_LSB +: 8];
   endfunction : split_fields

   assign opc    = instr_word[bts_pkg::OPC_LSB +: 4];                           // [RULE_01]
   assign fields = split_fields(instr_word);                                    // [RULE_01]
   // Idle cycles never decode: the prefetched word is thrown away there
   assign load   = (q_r == bts_pkg::Q1) && (st_r == bts_pkg::S_EXEC) && is_bit_test(opc);

   // ***********************************
   // Quarter-phase counter
   // ***********************************
   // One mclk edge per quarter, four per instruction cycle
   always_comb begin
      case (q_r)
         bts_pkg::Q1: q_nxt = bts_pkg::Q2;
         bts_pkg::Q2: q_nxt = bts_pkg::Q3;
         bts_pkg::Q3: q_nxt = bts_pkg::Q4;
         default:     q_nxt = bts_pkg::Q1;
      endcase
   end

   // ***********************************
   // Instruction sequencing
   // ***********************************
   // Fields held for the whole cycle; prefetch slots only idle
   always_comb begin
      st_nxt      = st_r;
      fld_nxt     = fld_r;
      set_pol_nxt = set_pol_r;
      bit_op_nxt  = bit_op_r;
      rd_en_nxt   = 1'b0;
      tested_nxt  = tested_r;
      skip_nxt    = skip_r;
      two_nxt     = two_r;
      discard_nxt = 1'b0;
      nop_nxt     = no_operation_r;
      done_nxt    = 1'b0;
      case (q_r)
         bts_pkg::Q1: begin
            bit_op_nxt = load;                                                   // [RULE_09]
            skip_nxt   = 1'b0;
            if (load) begin
               fld_nxt     = fields;
               set_pol_nxt = (opc == bts_pkg::OPC_SKIP_SET);                    // [RULE_02]
               rd_en_nxt   = 1'b1;                                               // [RULE_09]
            end
         end
         bts_pkg::Q2: begin
            // Bit picked while the read data stands
            if (bit_op_r)
               tested_nxt = file_rd_data[fld_r.bit_idx];                         // [RULE_09]
         end
         bts_pkg::Q3: begin
            // Prefetch length taken here, before any idle cycle starts
            if (bit_op_r) begin
               skip_nxt = (tested_r == set_pol_r);                               // [RULE_03] [RULE_02]
               two_nxt  = next_two_word;
            end
         end
         default: begin
            // Q4 writes nothing; no file or status update ever leaves here
            done_nxt = 1'b1;                                                     // [RULE_09]
            case (st_r)
               bts_pkg::S_EXEC: begin
                  if (skip_r) begin
                     st_nxt      = bts_pkg::S_IDLE1;                             // [RULE_04]
                     discard_nxt = 1'b1;
                     done_nxt    = 1'b0;
                  end
               end
               bts_pkg::S_IDLE1: begin
                  if (two_r) begin
                     st_nxt   = bts_pkg::S_IDLE2;                                // [RULE_05]
                     done_nxt = 1'b0;
                  end else begin
                     st_nxt = bts_pkg::S_EXEC;
                  end
               end
               default: st_nxt = bts_pkg::S_EXEC;
            endcase
            // From the next state, so the flag covers all four idle quarters
            nop_nxt = (st_nxt != bts_pkg::S_EXEC);                               // [RULE_06]
            // Test ends here when it skips; no stale result in the idle cycle
            if (st_nxt != bts_pkg::S_EXEC)
               bit_op_nxt = 1'b0;
         end
      endcase
   end

   // ***********************************
   // State registers
   // ***********************************
   // Register only; every decision sits in the comb block above
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q_r            <= bts_pkg::Q1;
         st_r           <= bts_pkg::S_EXEC;
         fld_r          <= '0;
         set_pol_r      <= 1'b0;
         bit_op_r       <= 1'b0;
         file_rd_en_r   <= 1'b0;
         tested_r       <= 1'b0;
         skip_r         <= 1'b0;
         two_r          <= 1'b0;
         discard_r      <= 1'b0;
         no_operation_r <= 1'b0;
         instr_done_r   <= 1'b0;
      end else begin
         q_r            <= q_nxt;
         st_r           <= st_nxt;
         fld_r          <= fld_nxt;
         set_pol_r      <= set_pol_nxt;
         bit_op_r       <= bit_op_nxt;
         file_rd_en_r   <= rd_en_nxt;
         tested_r       <= tested_nxt;
         skip_r         <= skip_nxt;
         two_r          <= two_nxt;
         discard_r      <= discard_nxt;
         no_operation_r <= nop_nxt;
         instr_done_r   <= done_nxt;
      end
   end

   // ***********************************
   // Phase output
   // ***********************************
   // Phase shown to the outside
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         q_phase_r <= bts_pkg::Q_RESET;
      else
         q_phase_r <= q_nxt;
   end

   // ***********************************
   // Operand address
   // ***********************************
   bts_addr_resolve u_addr (
      .mclk                 (mclk),
      .resetn               (resetn),
      .load                 (load),
      .fields               (fields),
      .ext_set_en           (ext_set_en),
      .bank_select_register (bank_select_register),
      .index_base           (index_base),
      .addr_r               (file_addr_r),
      .indexed_r            (indexed_r)
   );

endmodule : bts_decode

// ==== pkg/bts_pkg.sv ====
package bts_pkg;

   // ***********************************
   // Instruction word fields
   // ***********************************
   localparam int          WORD_W       = 16;
   localparam int          OPC_LSB      = 12;   // Top nibble
   localparam int          BIT_LSB      = 9;    // Bit index b
   localparam int          ACC_POS      = 8;    // Bank flag a
   localparam int          FILE_LSB     = 0;    // File address f
   localparam logic [3:0]  OPC_SKIP_CLR = 4'hb; // 1011
   localparam logic [3:0]  OPC_SKIP_SET = 4'ha; // 1010

   // ***********************************
   // Addressing
   // ***********************************
   localparam int          ADDR_W       = 12;
   localparam int          BANK_W       = 4;
   localparam logic [7:0]  INDEX_LIMIT  = 8'h5f; // f <= 95 goes indexed
   localparam logic [7:0]  ACCESS_SPLIT = 8'h60; // Upper access half
   localparam logic [3:0]  ACCESS_HIGH  = 4'hf;  // Bank of upper half
   localparam logic [3:0]  ACCESS_LOW   = 4'h0;  // Bank of lower half
   localparam logic [1:0]  Q_RESET      = 2'h0;

   // ***********************************
   // Types
   // ***********************************
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bts_quarter_t;

   typedef enum logic [1:0] {S_EXEC, S_IDLE1, S_IDLE2} bts_state_t;

   typedef struct packed {
      logic [2:0] bit_idx;
      logic       acc_flag;
      logic [7:0] file_addr;
   } bts_fields_t;

endpackage : bts_pkg

// ==== verification/bts_decode_bench.sv ====
`timescale 1ns/1ps
module bts_decode_bench;
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic        next_two_word = 1'b0;
   logic        ext_set_en = 1'b0;
   logic [3:0]  bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000;
   logic [7:0]  file_rd_data = 8'h00;
   logic [1:0]  q_phase_r;
   logic        bit_op_r, file_rd_en_r, indexed_r, skip_r;
   logic        discard_r, no_operation_r, instr_done_r;
   logic [11:0] file_addr_r;
   logic [13:0] notes[$];
   logic [13:0] n;
   logic [3:0]  outcome;
   int          failures = 0;
   int          total_checks = 0;
   int          cycles = 0;
   bts_pkg::bts_fields_t fl;
   bts_decode uut (
      .mclk                 (mclk),
      .resetn               (resetn),
      .instr_word           (instr_word),
      .next_two_word        (next_two_word),
      .ext_set_en           (ext_set_en),
      .bank_select_register (bank_select_register),
      .index_base           (index_base),
      .file_rd_data         (file_rd_data),
      .q_phase_r            (q_phase_r),
      .bit_op_r             (bit_op_r),
      .file_rd_en_r         (file_rd_en_r),
      .file_addr_r          (file_addr_r),
      .indexed_r            (indexed_r),
      .skip_r               (skip_r),
      .discard_r            (discard_r),
      .no_operation_r       (no_operation_r),
      .instr_done_r         (instr_done_r)
   );
   // Outcome flags of one test, done last
   assign outcome = {skip_r, discard_r, no_operation_r, instr_done_r};
   always #50 mclk = ~mclk;
   task automatic check(string what, logic [13:0] seen, logic [13:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // Drive one slot at the Q4 edge, note the outcome, wait out its cycles
   task automatic run(logic [3:0] op, bts_pkg::bts_fields_t f, logic tw, logic e);
      logic [7:0]  d;
      logic [3:0]  bs;
      logic [11:0] bx;
      logic [11:0] adr;
      logic        sk;
      logic        ix;
      d = 8'($urandom);
      bs = 4'($urandom);
      bx = 12'($urandom);
      sk = d[f.bit_idx] ^ op[0];
      ix = e && !f.acc_flag && f.file_addr <= bts_pkg::INDEX_LIMIT;
      if (f.acc_flag) adr = {bs, f.file_addr};
      else if (ix) adr = bx + 12'(f.file_addr);
      else if (f.file_addr < bts_pkg::ACCESS_SPLIT) adr = {bts_pkg::ACCESS_LOW, f.file_addr};
      else adr = {bts_pkg::ACCESS_HIGH, f.file_addr};
      instr_word <= {op, f};
      next_two_word <= tw;
      ext_set_en <= e;
      bank_select_register <= bs;
      index_base <= bx;
      file_rd_data <= d;
      if (op[3:1] == 3'h5) notes.push_back({sk, ix, adr});
      repeat ((op[3:1] == 3'h5 && sk) ? (tw ? 12 : 8) : 4) @(posedge mclk);
   endtask : run
   // Outcome seen in Q1 after the test cycle, compared against the oldest note
   always @(negedge mclk) begin
      if (resetn && q_phase_r == 2'h0 && (bit_op_r || skip_r)) begin
         if (notes.size() == 0) check("unexpected result", 14'h1, 14'h0);
         else begin
            n = notes.pop_front();
            check("skip", 14'(outcome), 14'({{3{n[13]}}, !n[13]}));
            check("address", 14'({indexed_r, file_addr_r}), 14'(n[12:0]));
         end
      end
   end
   // Hang guard, well beyond the longest run of slots
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      void'($urandom(11917));
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      // Boundary file addresses around the indexed limit, both opcodes
      for (int i = 0; i < 8; i++) begin
         fl = 12'($urandom);
         fl.acc_flag = 1'b0;
         fl.file_addr = i[1] ? (i[0] ? 8'h5f : 8'h60) : (i[0] ? 8'h00 : 8'hff);
         run(i[2] ? bts_pkg::OPC_SKIP_SET : bts_pkg::OPC_SKIP_CLR, fl, i[0], 1'b1);
      end
      run(4'h8, fl, 1'b0, 1'b0);
      $display("directed test done");
      // Random slots, refused opcodes mixed in back to back
      for (int i = 0; i < 60; i++) begin
         fl = 12'($urandom);
         run(4'h8 + 4'($urandom % 4), fl, 1'($urandom), 1'($urandom));
      end
      repeat (4) @(posedge mclk);
      check("notes left", 14'(notes.size()), 14'h0);
      $display("random test done");
      summarize();
   end
endmodule : bts_decode_bench

// ==== verification/bts_decode_props.sv ====
`timescale 1ns/1ps
// ****
// Skip-test timing checks
// ****
module bts_decode_chk (
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic [15:0] instr_word,
   input wire logic        next_two_word,
   input wire logic [7:0]  file_rd_data,
   input wire logic [1:0]  q_phase_r,
   input wire logic        bit_op_r,
   input wire logic        file_rd_en_r,
   input wire logic        skip_r,
   input wire logic        discard_r,
   input wire logic        no_operation_r,
   input wire logic        instr_done_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic       op0_c;
   logic [2:0] b_c;
   logic       bit_c;
   logic       two_c;
   wire        load = q_phase_r == 2'h0 && !no_operation_r;
   wire        q4 = q_phase_r == 2'h3;
   // Snapshot of the operands in flight, so skip can be tied to its cause
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         op0_c <= 1'b0;
         b_c <= 3'h0;
         bit_c <= 1'b0;
         two_c <= 1'b0;
      end else begin
         if (load) begin
            op0_c <= instr_word[12];
            b_c <= instr_word[11:9];
         end
         if (file_rd_en_r) bit_c <= file_rd_data[b_c];
         if (q_phase_r == 2'h2) two_c <= next_two_word;
      end
   end
   a_test_op_load: assert property (
      load && instr_word[15:13] == 3'h5 |=> file_rd_en_r && bit_op_r)
      else $error("test opcode not decoded");
   a_other_op_quiet: assert property (
      load && instr_word[15:13] != 3'h5 |=> !file_rd_en_r && !bit_op_r)
      else $error("other opcode started a test");
   a_read_in_q2: assert property (
      file_rd_en_r |-> q_phase_r == 2'h1 ##1 !file_rd_en_r)
      else $error("file read not a Q2 pulse");
   a_skip_cond: assert property (
      q4 && bit_op_r |-> skip_r == (bit_c ^ op0_c))
      else $error("skip decision wrong");
   a_skip_discard: assert property (
      q4 && skip_r |=> discard_r && no_operation_r ##1 !discard_r)
      else $error("prefetch not discarded once");
   a_idle_one: assert property (
      q4 && skip_r && !two_c |=> no_operation_r [*4] ##1 !no_operation_r)
      else $error("single idle cycle length wrong");
   a_idle_two: assert property (
      q4 && skip_r && two_c |=> no_operation_r [*8] ##1 !no_operation_r)
      else $error("double idle cycle length wrong");
   a_no_skip_done: assert property (
      q4 && bit_op_r && !skip_r |=> instr_done_r && !no_operation_r)
      else $error("no-skip test not one cycle");
   a_end_done_one: assert property (
      q4 && skip_r && !two_c |=> !instr_done_r [*4] ##1 instr_done_r)
      else $error("done not after single idle cycle");
   a_end_done_two: assert property (
      q4 && skip_r && two_c |=> !instr_done_r [*8] ##1 instr_done_r)
      else $error("done not after double idle cycle");
endmodule : bts_decode_chk

bind bts_decode bts_decode_chk chk (
   .mclk           (mclk),
   .resetn         (resetn),
   .instr_word     (instr_word),
   .next_two_word  (next_two_word),
   .file_rd_data   (file_rd_data),
   .q_phase_r      (q_phase_r),
   .bit_op_r       (bit_op_r),
   .file_rd_en_r   (file_rd_en_r),
   .skip_r         (skip_r),
   .discard_r      (discard_r),
   .no_operation_r (no_operation_r),
   .instr_done_r   (instr_done_r)
);
